/* rtl/trs_top.sv */
// Register set of a digital thermometer: result, trip points, configuration.
// Assumes a command decoder on SYS_CLK drives the register port and the
// conversion commands, and that SENSOR_TEMP comes from an unclocked converter.
`timescale 1ns/100ps
module trs_top #(
    parameter int unsigned CONV_CYCLES_12 = trs_pkg::CONV_CYCLES_12_DFLT,
    parameter int unsigned NV_WRITE_CYCLES = trs_pkg::NV_WRITE_CYCLES_DFLT
) (
    input wire logic SYS_CLK,
    input wire logic RESETN,
    input wire logic [1:0] REG_SEL,
    input wire logic REG_WR,
    input wire logic [15:0] REG_WDATA,
    output logic [15:0] REG_RDATA,
    input wire logic CONV_START,
    input wire logic CONV_STOP,
    input wire logic [15:0] SENSOR_TEMP,
    output logic TOUT
);

    // ---------------------------------------------------------------
    // Reset and sensor synchronisers
    // ---------------------------------------------------------------
    logic rst_meta_ff;
    logic rst_n;
    logic [15:0] sens_meta_ff;
    logic [15:0] sens_sync_ff;

    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            rst_meta_ff <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n <= rst_meta_ff;
        end
    end

    // The sensor word is assumed stable while a conversion settles; the bits
    // are synchronised one by one, not as a coherent word.
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            sens_meta_ff <= '0;
            sens_sync_ff <= '0;
        end else begin
            sens_meta_ff <= SENSOR_TEMP;
            sens_sync_ff <= sens_meta_ff;
        end
    end

    // ---------------------------------------------------------------
    // Nonvolatile store
    // ---------------------------------------------------------------
    logic [15:0] upper_raw;
    logic [15:0] lower_raw;
    logic [1:0] cfg_nv;
    logic nv_busy;

    trs_nv_store #(
        .NV_WRITE_CYCLES(NV_WRITE_CYCLES)
    ) u_nv (
        .clk(SYS_CLK),
        .rst_n(rst_n),
        .wr_req(REG_WR),
        .wr_sel(REG_SEL),
        .wr_data(REG_WDATA),
        .upper_ff(upper_raw),
        .lower_ff(lower_raw),
        .cfg_nv_ff(cfg_nv),
        .busy_ff(nv_busy)
    );

    // ---------------------------------------------------------------
    // Volatile state
    // ---------------------------------------------------------------
    trs_pkg::trs_state_e state_ff;
    logic [trs_pkg::CNT_W-1:0] cnt_ff;
    logic [trs_pkg::CNT_W-1:0] conv_limit;
    logic [15:0] temp_ff;
    logic [1:0] res_ff;
    logic done_ff;
    logic high_flag_ff;
    logic low_flag_ff;
    logic tout_active_ff;
    logic [15:0] mask;
    logic [15:0] upper_m;
    logic [15:0] lower_m;
    logic [15:0] sample_m;
    logic capture;
    logic cfg_wr;
    logic high_event;
    logic low_event;
    logic [7:0] cfg_value;

    assign mask = trs_pkg::trs_res_mask(res_ff);
    assign upper_m = upper_raw & mask;
    assign lower_m = lower_raw & mask;
    assign sample_m = sens_sync_ff & mask;
    assign cfg_wr = REG_WR && (REG_SEL == trs_pkg::SEL_CFG);
    // Each bit of resolution below twelve halves the conversion time.
    assign conv_limit = trs_pkg::CNT_W'(CONV_CYCLES_12 >> (~res_ff));
    assign capture = (state_ff == trs_pkg::ST_CONV) && (cnt_ff == conv_limit - 1'b1);
    assign high_event = capture && ($signed(sample_m) > $signed(upper_m));
    assign low_event = capture && ($signed(sample_m) < $signed(lower_m));
    assign cfg_value = {done_ff, high_flag_ff, low_flag_ff, nv_busy, res_ff, cfg_nv};

    // ---------------------------------------------------------------
    // Conversion sequencer
    // ---------------------------------------------------------------
    // A stop command wins over a start issued in the same cycle.
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= trs_pkg::ST_IDLE;
            cnt_ff <= '0;
        end else if (CONV_STOP) begin
            state_ff <= trs_pkg::ST_IDLE;
        end else begin
            case (state_ff)
                trs_pkg::ST_IDLE: begin
                    if (CONV_START) begin
                        state_ff <= trs_pkg::ST_CONV;
                        cnt_ff <= '0;
                    end
                end
                trs_pkg::ST_CONV: begin
                    if (capture) begin
                        cnt_ff <= '0;
                        if (cfg_nv[trs_pkg::CFG_SINGLE]) begin
                            state_ff <= trs_pkg::ST_IDLE;
                        end
                    end else begin
                        cnt_ff <= cnt_ff + 1'b1;
                    end
                end
                default: state_ff <= trs_pkg::ST_IDLE;
            endcase
        end
    end

    // Only a finished conversion loads the result; register writes never do.
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            temp_ff <= trs_pkg::TEMP_RESET;
        end else if (capture) begin
            temp_ff <= sample_m;
        end
    end

    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            done_ff <= trs_pkg::CFG_HI_RESET[trs_pkg::CFG_DONE-2];
        end else if (capture) begin
            done_ff <= 1'b1;
        end else if (state_ff == trs_pkg::ST_IDLE && CONV_START && !CONV_STOP) begin
            done_ff <= 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            res_ff <= trs_pkg::RES_RESET;
        end else if (cfg_wr) begin
            res_ff <= REG_WDATA[trs_pkg::CFG_RES_HIGH:trs_pkg::CFG_RES_LOW];
        end
    end

    // Software may only clear a flag; an excursion in the same cycle wins.
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            high_flag_ff <= 1'b0;
            low_flag_ff <= 1'b0;
        end else begin
            if (high_event) begin
                high_flag_ff <= 1'b1;
            end else if (cfg_wr && !REG_WDATA[trs_pkg::CFG_HIGH_FLAG]) begin
                high_flag_ff <= 1'b0;
            end
            if (low_event) begin
                low_flag_ff <= 1'b1;
            end else if (cfg_wr && !REG_WDATA[trs_pkg::CFG_LOW_FLAG]) begin
                low_flag_ff <= 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // Thermostat output and read port
    // ---------------------------------------------------------------
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            tout_active_ff <= 1'b0;
            TOUT <= trs_pkg::TOUT_RESET;
        end else begin
            if (capture && $signed(sample_m) >= $signed(upper_m)) begin
                tout_active_ff <= 1'b1;
            end else if (low_event) begin
                tout_active_ff <= 1'b0;
            end
            TOUT <= tout_active_ff ~^ cfg_nv[trs_pkg::CFG_POLARITY];
        end
    end

    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            REG_RDATA <= '0;
        end else begin
            case (REG_SEL)
                trs_pkg::SEL_TEMP: REG_RDATA <= temp_ff;
                trs_pkg::SEL_UPPER: REG_RDATA <= upper_m;
                trs_pkg::SEL_LOWER: REG_RDATA <= lower_m;
                trs_pkg::SEL_CFG: REG_RDATA <= {8'h00, cfg_value};
                default: REG_RDATA <= '0;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    property p_temp_hold;
        @(posedge SYS_CLK) disable iff (!rst_n)
        !capture |=> $stable(temp_ff);
    endproperty
    a_temp_hold: assert property (p_temp_hold) else $error("result changed without conversion");

    property p_temp_write_ignored;
        @(posedge SYS_CLK) disable iff (!rst_n)
        REG_WR && REG_SEL == trs_pkg::SEL_TEMP && !capture |=> temp_ff == $past(temp_ff);
    endproperty
    a_temp_write_ignored: assert property (p_temp_write_ignored) else $error("result was written");

    property p_cfg_reset;
        @(posedge SYS_CLK)
        $rose(rst_n) |-> cfg_value[7:2] == trs_pkg::CFG_HI_RESET && temp_ff == trs_pkg::TEMP_RESET;
    endproperty
    a_cfg_reset: assert property (p_cfg_reset) else $error("wrong state after reset");

    property p_conv_bound;
        @(posedge SYS_CLK) disable iff (!rst_n)
        state_ff == trs_pkg::ST_CONV |-> cnt_ff < conv_limit;
    endproperty
    a_conv_bound: assert property (p_conv_bound) else $error("conversion overran");

    property p_res_mask;
        @(posedge SYS_CLK) disable iff (!rst_n)
        capture && !cfg_wr |=> (temp_ff & ~trs_pkg::trs_res_mask(res_ff)) == 16'h0000;
    endproperty
    a_res_mask: assert property (p_res_mask) else $error("result holds unused bits");

    property p_flag_set;
        @(posedge SYS_CLK) disable iff (!rst_n)
        high_event |=> high_flag_ff ##1 high_flag_ff || $past(cfg_wr);
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("high flag not set");

    property p_flag_sticky;
        @(posedge SYS_CLK) disable iff (!rst_n)
        low_flag_ff && !cfg_wr |=> low_flag_ff;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("low flag dropped by itself");

    c_conv_done: cover property (@(posedge SYS_CLK) disable iff (!rst_n) capture);
    c_single_idle: cover property (@(posedge SYS_CLK) disable iff (!rst_n)
        capture && cfg_nv[trs_pkg::CFG_SINGLE] ##1 state_ff == trs_pkg::ST_IDLE);
    c_high_flag: cover property (@(posedge SYS_CLK) disable iff (!rst_n) $rose(high_flag_ff));

endmodule : trs_top

/* rtl/trs_pkg.sv */
// Constants, types and helpers shared by the thermometer register set.
// Assumes a 50 MHz system clock; long counts are overridable from the top.
package trs_pkg;

    // ---------------------------------------------------------------
    // Clock and timing
    // ---------------------------------------------------------------
    localparam int unsigned CLK_KHZ = 50000;
    localparam int unsigned CONV_TIME_12_MS = 750;
    localparam int unsigned NV_WRITE_TIME_MS = 10;
    localparam int unsigned CONV_CYCLES_12_DFLT = CONV_TIME_12_MS * CLK_KHZ;
    localparam int unsigned NV_WRITE_CYCLES_DFLT = NV_WRITE_TIME_MS * CLK_KHZ;
    localparam int CNT_W = 26;

    // ---------------------------------------------------------------
    // Register selection codes
    // ---------------------------------------------------------------
    localparam logic [1:0] SEL_TEMP = 2'h0;
    localparam logic [1:0] SEL_UPPER = 2'h1;
    localparam logic [1:0] SEL_LOWER = 2'h2;
    localparam logic [1:0] SEL_CFG = 2'h3;

    // ---------------------------------------------------------------
    // Reset and factory values
    // ---------------------------------------------------------------
    localparam logic [15:0] TEMP_RESET = 16'hC400;
    localparam logic [15:0] UPPER_FACTORY = 16'h0F00;
    localparam logic [15:0] LOWER_FACTORY = 16'h0A00;
    localparam logic [1:0] CFG_NV_FACTORY = 2'h0;
    localparam logic [5:0] CFG_HI_RESET = 6'h23;
    localparam logic [1:0] RES_RESET = 2'h3;
    localparam logic TOUT_RESET = 1'b1;

    // ---------------------------------------------------------------
    // Configuration bit positions
    // ---------------------------------------------------------------
    localparam int CFG_DONE = 7;
    localparam int CFG_HIGH_FLAG = 6;
    localparam int CFG_LOW_FLAG = 5;
    localparam int CFG_NV_BUSY = 4;
    localparam int CFG_RES_HIGH = 3;
    localparam int CFG_RES_LOW = 2;
    localparam int CFG_POLARITY = 1;
    localparam int CFG_SINGLE = 0;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h1,
        ST_CONV = 2'h2
    } trs_state_e;

    // Keeps the data bits that the given resolution uses; 12 bits at code 3.
    function automatic logic [15:0] trs_res_mask(input logic [1:0] res);
        logic [15:0] m;
        m = 16'hFF80;
        case (res)
            2'h1: m = 16'hFFC0;
            2'h2: m = 16'hFFE0;
            2'h3: m = 16'hFFF0;
            default: m = 16'hFF80;
        endcase
        return m;
    endfunction : trs_res_mask

endpackage : trs_pkg

/* rtl/trs_nv_store.sv */
// Nonvolatile store of the trip points and the two nonvolatile config bits.
// Assumes single-cycle write requests from the register logic on one clock.
`timescale 1ns/100ps
module trs_nv_store #(
    parameter int unsigned NV_WRITE_CYCLES = trs_pkg::NV_WRITE_CYCLES_DFLT
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wr_req,
    input wire logic [1:0] wr_sel,
    input wire logic [15:0] wr_data,
    output logic [15:0] upper_ff,
    output logic [15:0] lower_ff,
    output logic [1:0] cfg_nv_ff,
    output logic busy_ff
);

    logic [1:0] pend_sel_ff;
    logic [15:0] pend_data_ff;
    logic [trs_pkg::CNT_W-1:0] wcnt_ff;
    logic accept;
    logic commit;

    // A request while a write is in progress is dropped, as the cell is busy.
    assign accept = wr_req && !busy_ff && (wr_sel != trs_pkg::SEL_TEMP);
    assign commit = busy_ff && (wcnt_ff == trs_pkg::CNT_W'(NV_WRITE_CYCLES - 1));

    // ---------------------------------------------------------------
    // Write timer
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_ff <= 1'b0;
            wcnt_ff <= '0;
            pend_sel_ff <= trs_pkg::SEL_TEMP;
            pend_data_ff <= '0;
        end else if (accept) begin
            busy_ff <= 1'b1;
            wcnt_ff <= '0;
            pend_sel_ff <= wr_sel;
            pend_data_ff <= wr_data;
        end else if (commit) begin
            busy_ff <= 1'b0;
        end else if (busy_ff) begin
            wcnt_ff <= wcnt_ff + 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // Stored values
    // ---------------------------------------------------------------
    // The reset stands for a power cycle, so the cells come back at factory state.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            upper_ff <= trs_pkg::UPPER_FACTORY;
            lower_ff <= trs_pkg::LOWER_FACTORY;
            cfg_nv_ff <= trs_pkg::CFG_NV_FACTORY;
        end else if (commit) begin
            case (pend_sel_ff)
                trs_pkg::SEL_UPPER: upper_ff <= pend_data_ff;
                trs_pkg::SEL_LOWER: lower_ff <= pend_data_ff;
                trs_pkg::SEL_CFG: cfg_nv_ff <= pend_data_ff[1:0];
                default: upper_ff <= upper_ff;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    property p_upper_commit;
        @(posedge clk) disable iff (!rst_n)
        !$stable(upper_ff) |-> $past(commit) && $past(pend_sel_ff) == trs_pkg::SEL_UPPER;
    endproperty
    a_upper_commit: assert property (p_upper_commit) else $error("upper trip point changed without commit");

    property p_lower_commit;
        @(posedge clk) disable iff (!rst_n)
        !$stable(lower_ff) |-> $past(commit) && $past(pend_sel_ff) == trs_pkg::SEL_LOWER;
    endproperty
    a_lower_commit: assert property (p_lower_commit) else $error("lower trip point changed without commit");

    property p_cfg_nv_commit;
        @(posedge clk) disable iff (!rst_n)
        !$stable(cfg_nv_ff) |-> $past(commit) && $past(pend_sel_ff) == trs_pkg::SEL_CFG;
    endproperty
    a_cfg_nv_commit: assert property (p_cfg_nv_commit) else $error("nv config bits changed without commit");

    property p_write_busy;
        @(posedge clk) disable iff (!rst_n)
        accept |=> busy_ff[*2];
    endproperty
    a_write_busy: assert property (p_write_busy) else $error("nv write did not hold busy");

    property p_write_bound;
        @(posedge clk) disable iff (!rst_n)
        busy_ff |-> wcnt_ff < trs_pkg::CNT_W'(NV_WRITE_CYCLES);
    endproperty
    a_write_bound: assert property (p_write_bound) else $error("nv write ran past its time");

    c_nv_commit: cover property (@(posedge clk) disable iff (!rst_n) commit);

endmodule : trs_nv_store

/* test/trs_host_model.sv */
// Behavioural command side that drives the register port and conversion strobes.
// Assumes the caller enters each task just after a rising edge of clk.
`timescale 1ns/100ps
module trs_host_model #(
    parameter int unsigned NV_GAP = 9
) (
    input wire logic clk,
    output logic [1:0] sel,
    output logic wr,
    output logic [15:0] wdata,
    output logic start,
    output logic stop,
    output logic rd_valid
);
    int since_nv = 1000;

    initial begin
        sel = 2'h0;
        wr = 1'b0;
        wdata = 16'h0000;
        start = 1'b0;
        stop = 1'b0;
        rd_valid = 1'b0;
    end

    always @(posedge clk) since_nv <= since_nv + 1;

    // --------------------------------------------------------------
    // Register port
    // --------------------------------------------------------------
    // A polite writer keeps off nonvolatile storage until the last write has settled.
    task automatic write(input logic [1:0] s, input logic [15:0] d, input bit polite);
        if (polite && s != trs_pkg::SEL_TEMP) begin
            while (since_nv < NV_GAP) begin
                @(posedge clk);
                #1;
            end
        end
        sel = s;
        wr = 1'b1;
        wdata = d;
        @(posedge clk);
        #1;
        wr = 1'b0;
        wdata = ~d;
        if (s != trs_pkg::SEL_TEMP) since_nv = 0;
    endtask : write

    // Two edges settle the registered read data before it is flagged valid.
    task automatic read(input logic [1:0] s);
        sel = s;
        repeat (2) @(posedge clk);
        #1;
        rd_valid = 1'b1;
        @(posedge clk);
        #1;
        rd_valid = 1'b0;
    endtask : read

    task automatic conv(input bit go);
        start = go;
        stop = !go;
        @(posedge clk);
        #1;
        start = 1'b0;
        stop = 1'b0;
    endtask : conv
endmodule : trs_host_model

/* test/thermometer_register_set_bench.sv */
// Self-checking bench for the thermometer register set.
// Assumes trs_top and the host model; long counts are shortened by parameters.
`timescale 1ns/100ps
module thermometer_register_set_bench;
    localparam int unsigned CONV12 = 64;
    localparam int unsigned NVW = 8;
    logic SYS_CLK;
    logic RESETN;
    logic [1:0] REG_SEL;
    logic REG_WR;
    logic [15:0] REG_WDATA;
    logic [15:0] REG_RDATA;
    logic CONV_START;
    logic CONV_STOP;
    logic [15:0] SENSOR_TEMP;
    logic TOUT;
    logic rd_valid;
    logic [15:0] exp_q[$];
    logic [15:0] exp_v;
    logic [15:0] sensor;
    logic [15:0] mask;
    int n_mismatch = 0;
    int checked = 0;
    int seed = 69;

    initial begin
        SYS_CLK = 1'b0;
        forever #10 SYS_CLK = ~SYS_CLK;
    end

    trs_top #(.CONV_CYCLES_12(CONV12), .NV_WRITE_CYCLES(NVW)) dut (
        .SYS_CLK(SYS_CLK), .RESETN(RESETN), .REG_SEL(REG_SEL), .REG_WR(REG_WR),
        .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .CONV_START(CONV_START),
        .CONV_STOP(CONV_STOP), .SENSOR_TEMP(SENSOR_TEMP), .TOUT(TOUT)
    );

    trs_host_model #(.NV_GAP(NVW + 1)) host (
        .clk(SYS_CLK), .sel(REG_SEL), .wr(REG_WR), .wdata(REG_WDATA),
        .start(CONV_START), .stop(CONV_STOP), .rd_valid(rd_valid)
    );

    // --------------------------------------------------------------
    // Checking
    // --------------------------------------------------------------
    // Reads are compared mid-cycle, clear of the edge that refreshes the read data.
    always @(negedge SYS_CLK) begin
        if (rd_valid === 1'b1) begin
            exp_v = exp_q.pop_front();
            checked++;
            if (REG_RDATA !== exp_v) begin
                n_mismatch++;
                $display("CHECK FAILED %0t read %h expected %h", $time, REG_RDATA, exp_v);
            end
        end
    end

    task automatic rd(input logic [1:0] s, input logic [15:0] e);
        exp_q.push_back(e);
        host.read(s);
    endtask : rd

    task automatic tout_is(input logic e);
        checked++;
        if (TOUT !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %0t thermostat output %b expected %b", $time, TOUT, e);
        end
    endtask : tout_is

    task automatic idle(input int n);
        repeat (n) @(posedge SYS_CLK);
        #1;
    endtask : idle

    task automatic conclude();
        $display("checked %0d n_mismatch %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : conclude

    // --------------------------------------------------------------
    // Stimulus
    // --------------------------------------------------------------
    initial begin
        RESETN = 1'b0;
        SENSOR_TEMP = 16'h0000;
        repeat (16) @(posedge SYS_CLK);
        #1;
        RESETN = 1'b1;
        idle(4);
        rd(trs_pkg::SEL_TEMP, 16'hC400);
        rd(trs_pkg::SEL_UPPER, 16'h0F00);
        rd(trs_pkg::SEL_LOWER, 16'h0A00);
        rd(trs_pkg::SEL_CFG, 16'h008C);
        tout_is(1'b1);
        host.write(trs_pkg::SEL_TEMP, 16'h1234, 1'b1);
        rd(trs_pkg::SEL_TEMP, 16'hC400);
        // A write that lands while storage is busy must be dropped.
        host.write(trs_pkg::SEL_UPPER, 16'h1F5A, 1'b1);
        rd(trs_pkg::SEL_CFG, 16'h009C);
        host.write(trs_pkg::SEL_LOWER, 16'h7777, 1'b0);
        rd(trs_pkg::SEL_UPPER, 16'h0F00);
        idle(NVW + 2);
        rd(trs_pkg::SEL_UPPER, 16'h1F50);
        rd(trs_pkg::SEL_LOWER, 16'h0A00);
        rd(trs_pkg::SEL_CFG, 16'h008C);
        host.write(trs_pkg::SEL_LOWER, 16'h0500, 1'b1);
        idle(NVW + 2);
        rd(trs_pkg::SEL_LOWER, 16'h0500);
        // Every resolution in single mode, with timing probed on both sides of the end.
        for (int r = 0; r < 4; r++) begin
            mask = 16'hFFF0 << (3 - r);
            host.write(trs_pkg::SEL_CFG, 16'(r << 2) | 16'h0003, 1'b1);
            idle(NVW + 2);
            sensor = 16'h0600 + 16'($random(seed) & 32'h0FFF);
            SENSOR_TEMP = sensor;
            rd(trs_pkg::SEL_UPPER, 16'h1F5A & mask);
            host.conv(1'b1);
            idle((CONV12 >> (3 - r)) - 6);
            rd(trs_pkg::SEL_CFG, 16'(r << 2) | 16'h0003);
            idle(4);
            rd(trs_pkg::SEL_CFG, 16'(r << 2) | 16'h0083);
            rd(trs_pkg::SEL_TEMP, sensor & mask);
        end
        SENSOR_TEMP = 16'h3000;
        host.conv(1'b1);
        idle(CONV12 + 6);
        rd(trs_pkg::SEL_CFG, 16'h00CF);
        tout_is(1'b1);
        SENSOR_TEMP = 16'h0100;
        host.conv(1'b1);
        idle(CONV12 + 6);
        rd(trs_pkg::SEL_CFG, 16'h00EF);
        tout_is(1'b0);
        host.write(trs_pkg::SEL_CFG, 16'h00EF, 1'b1);
        idle(NVW + 2);
        rd(trs_pkg::SEL_CFG, 16'h00EF);
        host.write(trs_pkg::SEL_CFG, 16'h000E, 1'b1);
        idle(NVW + 2);
        rd(trs_pkg::SEL_CFG, 16'h008E);
        // Continuous mode keeps converting until it is stopped.
        SENSOR_TEMP = 16'h0800;
        host.conv(1'b1);
        idle(CONV12 + 6);
        SENSOR_TEMP = 16'h0900;
        idle(CONV12 + 6);
        rd(trs_pkg::SEL_TEMP, 16'h0900);
        host.conv(1'b0);
        idle(2);
        SENSOR_TEMP = 16'h0A00;
        idle(2 * CONV12);
        rd(trs_pkg::SEL_TEMP, 16'h0900);
        conclude();
    end

    initial begin
        #400000;
        n_mismatch++;
        $display("CHECK FAILED %0t watchdog expired", $time);
        conclude();
    end
endmodule : thermometer_register_set_bench
